// >>> fbss_mains.sv
// Mains sampler with brownin, brownout, slope and disconnection detection.
`timescale 1ns/100ps
`default_nettype none
module fbss_mains #(
  parameter int unsigned CW = 8
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // Timebase and state.
  input wire logic tick,
  input wire logic running,
  input wire logic burst,
  // Digitised mains current and its comparison levels.
  input wire logic sample_valid,
  input wire logic [CW-1:0] sample_code,
  input wire logic [CW-1:0] brownin_lvl,
  input wire logic [CW-1:0] brownout_lvl,
  input wire logic [CW-1:0] high_lvl,
  // Results.
  output logic sample_pull,
  output logic discharge,
  output logic above_brownin,
  output logic brownout,
  output logic mains_present,
  output logic [CW-1:0] last_code
);

  logic [6:0] susp_q;
  logic [5:0] bo_cnt_q;
  logic [5:0] ns_cnt_q;
  logic pull_q;
  logic [CW-1:0] code_q;
  logic bi_q;
  logic pres_q;
  logic dis_q;

  // Crossing a level upward between two successive samples.
  function automatic logic crossed(input logic [CW-1:0] prev, input logic [CW-1:0] now, input logic [CW-1:0] lvl);
    crossed = (prev < lvl) && (now >= lvl);
  endfunction : crossed

  wire rise = sample_valid && (crossed(code_q, sample_code, brownin_lvl) ||
                               crossed(code_q, sample_code, high_lvl));
  wire low = sample_valid && (sample_code < brownout_lvl);
  wire [6:0] susp_len = burst ? 7'(fbss_pkg::SUSPEND_BURST_MS) : 7'(fbss_pkg::SUSPEND_MS);

  // Sampling, suspension and disconnection timing all advance on the ms tick.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      susp_q <= 7'h00;
      bo_cnt_q <= 6'h00;
      ns_cnt_q <= 6'h00;
      pull_q <= 1'b0;
      code_q <= '0;
      bi_q <= 1'b0;
      pres_q <= 1'b0;
      dis_q <= 1'b0;
    end else if (clk_en) begin
      pull_q <= tick && (susp_q == 7'h00);
      if (sample_valid) begin
        code_q <= sample_code;
        bi_q <= sample_code > brownin_lvl;
      end
      if (rise) begin
        pres_q <= 1'b1;
        susp_q <= susp_len;
        ns_cnt_q <= 6'h00;
        dis_q <= 1'b0;
      end else if (tick) begin
        if (susp_q != 7'h00) begin
          susp_q <= susp_q - 7'h01;
        end
        if (ns_cnt_q >= 6'(fbss_pkg::DISCONNECT_MS - 1)) begin
          dis_q <= 1'b1;
          pres_q <= 1'b0;
        end else if (susp_q == 7'h00) begin
          ns_cnt_q <= ns_cnt_q + 6'h01;
        end
      end
      // Any sample at or above brownout restarts the 30 ms window; a suspension pauses it.
      if (!running || (sample_valid && !low)) begin
        bo_cnt_q <= 6'h00;
      end else if (tick && susp_q == 7'h00 && bo_cnt_q < 6'(fbss_pkg::BROWNOUT_MS)) begin
        bo_cnt_q <= bo_cnt_q + 6'h01;
      end
    end
  end

  // Discharge holds the pin low continuously; otherwise it pulses per sample.
  assign sample_pull = pull_q || dis_q;
  assign discharge = dis_q;
  assign above_brownin = bi_q;
  assign brownout = bo_cnt_q >= 6'(fbss_pkg::BROWNOUT_MS);
  assign mains_present = pres_q;
  assign last_code = code_q;

endmodule : fbss_mains
`default_nettype wire

// >>> fbss_pkg.sv
// Package with shared constants and types for the flyback supervisory sequencer.
`default_nettype none
package fbss_pkg;

  // Core clock rate in kHz (250 MHz).
  localparam int unsigned CLK_KHZ = 250000;
  // Timebase period in ms and its cycle count.
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = TICK_MS * CLK_KHZ;
  // Mains supervision times in ms.
  localparam int unsigned BROWNOUT_MS = 30;
  localparam int unsigned SUSPEND_MS = 6;
  localparam int unsigned SUSPEND_BURST_MS = 97;
  localparam int unsigned DISCONNECT_MS = 28;
  // Fault input filter: a count of ticks gives 2 ms to 3 ms with tick jitter.
  localparam int unsigned FAULT_FILTER_MS = 3;
  // Overvoltage qualification count (gate pulses or ticks).
  localparam int unsigned OVP_COUNT = 4;
  // Overpower timeouts in ms.
  localparam int unsigned OPP_RUN_MS = 200;
  localparam int unsigned OPP_START_MS = 40;
  // Restart delay in ms (plain default).
  localparam int unsigned RESTART_MS = 100;
  // Maximum on-time in ns and cycles (longest time rounds down).
  localparam int unsigned MAX_ON_NS = 55000;
  localparam int unsigned MAX_ON_CYCLES = MAX_ON_NS * (CLK_KHZ / 1000) / 1000;

  // AHB-Lite register byte offsets.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] MAINS_OFF = 8'h08;
  localparam logic [7:0] CAUSE_OFF = 8'h0c;
  // Control register fields and reset value.
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_RST_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // Cause register bit positions.
  localparam int unsigned CS_AUX = 0;
  localparam int unsigned CS_BO = 1;
  localparam int unsigned CS_ONT = 2;
  localparam int unsigned CS_OTP = 3;
  localparam int unsigned CS_FLT = 4;
  localparam int unsigned CS_OVP = 5;
  localparam int unsigned CS_OPP = 6;
  localparam int unsigned CS_UV = 7;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_LOCKOUT, ST_WAIT_START, ST_RUN, ST_RESTART_WAIT, ST_BROWN_WAIT, ST_AUX_WAIT
  } fbss_state_e;

  // Operating modes.
  typedef enum logic [1:0] {
    MD_VALLEY, MD_DCM_SKIP, MD_VCO, MD_BURST
  } fbss_mode_e;

endpackage : fbss_pkg
`default_nettype wire

// >>> fbss_prot.sv
// Protection qualifiers: fault filter, overvoltage counter, overpower timer, on-time cap.
`timescale 1ns/100ps
`default_nettype none
module fbss_prot (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // Timebase and context.
  input wire logic tick,
  input wire logic running,
  input wire logic in_regulation,
  input wire logic gate_rise,
  input wire logic gate_on,
  // Raw conditions.
  input wire logic fault_low,
  input wire logic ovp_aux,
  input wire logic ovp_rail,
  input wire logic overpower,
  // Qualified trips.
  output logic fault_trip,
  output logic ovp_trip,
  output logic opp_trip,
  output logic ontime_trip
);

  logic [2:0] flt_q;
  logic [2:0] ovp_q;
  logic [7:0] opp_q;
  logic [14:0] on_q;

  wire ovp = ovp_aux || ovp_rail;
  // Low fault input swaps the counter clock to the ms tick.
  wire ovp_clk = fault_low ? tick : gate_rise;
  wire [7:0] opp_lim = in_regulation ? 8'(fbss_pkg::OPP_RUN_MS) : 8'(fbss_pkg::OPP_START_MS);

  // Each counter clears as soon as its condition goes away.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_q <= 3'h0;
      ovp_q <= 3'h0;
      opp_q <= 8'h00;
      on_q <= 15'h0000;
    end else if (clk_en) begin
      if (!fault_low) begin
        flt_q <= 3'h0;
      end else if (tick && flt_q < 3'(fbss_pkg::FAULT_FILTER_MS)) begin
        flt_q <= flt_q + 3'h1;
      end
      if (!ovp || !running) begin
        ovp_q <= 3'h0;
      end else if (ovp_clk && ovp_q < 3'(fbss_pkg::OVP_COUNT)) begin
        ovp_q <= ovp_q + 3'h1;
      end
      if (!overpower || !running) begin
        opp_q <= 8'h00;
      end else if (tick && opp_q < opp_lim) begin
        opp_q <= opp_q + 8'h01;
      end
      on_q <= gate_on ? on_q + 15'h0001 : 15'h0000;
    end
  end

  assign fault_trip = flt_q >= 3'(fbss_pkg::FAULT_FILTER_MS);
  assign ovp_trip = ovp_q >= 3'(fbss_pkg::OVP_COUNT);
  assign opp_trip = opp_q >= opp_lim;
  assign ontime_trip = on_q >= 15'(fbss_pkg::MAX_ON_CYCLES);

endmodule : fbss_prot
`default_nettype wire

// >>> fbss_stage_model.sv
// Behavioural model of the mains sampler and the winding events of the power stage.
`timescale 1ns/100ps
`default_nettype none
module fbss_stage_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Pin pull and gate from the sequencer, mains peak from the bench.
  input wire logic pull,
  input wire logic gate_start,
  input wire logic [7:0] amp,
  // Sample and winding events.
  output logic mains_valid,
  output logic [7:0] mains_code,
  output logic demag_done,
  output logic valley_seen,
  output logic cycle_end
);
  logic pull_q;
  logic phase_q;
  logic [3:0] ring_q;
  // Demag and valley only once the ring after a gate pulse has died out.
  assign demag_done = (ring_q == 4'h0);
  assign valley_seen = demag_done;
  assign cycle_end = (ring_q == 4'h1);
  // Samples alternate zero and peak so each pair is a rising slope; the code scrambles between samples.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_q <= 1'b0;
      phase_q <= 1'b0;
      ring_q <= 4'h0;
      mains_valid <= 1'b0;
      mains_code <= 8'h00;
    end else begin
      pull_q <= pull;
      mains_valid <= pull && !pull_q;
      phase_q <= phase_q ^ (pull && !pull_q);
      mains_code <= (pull && !pull_q) ? (phase_q ? amp : 8'h00) : ~mains_code;
      ring_q <= gate_start ? 4'h8 : ring_q - {3'h0, ring_q != 4'h0};
    end
  end
endmodule : fbss_stage_model
`default_nettype wire

// >>> fbss_sva.sv
// Concurrent checks on the ports of the flyback supervisory sequencer top.
`timescale 1ns/100ps
`default_nettype none
module fbss_sva (
  // Clock, reset and bus answer.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  // Causes seen at the inputs.
  input wire logic low_rail_below_handover,
  input wire logic fault_above_hys,
  input wire logic control_at_max,
  input wire logic aux_open,
  input wire logic demag_done,
  input wire logic valley_seen,
  // Outputs under watch.
  input wire logic rail_regulator_on,
  input wire logic mains_supply_on,
  input wire logic switching_enable,
  input wire logic gate_start,
  input wire logic min_peak,
  input wire logic [1:0] op_mode
);
  // One clock domain, so reset masks every check in one place.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_rail_reg_follow: assert property (rail_regulator_on == low_rail_below_handover)
    else $error("regulator does not track the handover comparator");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  a_start_gated: assert property ($rose(switching_enable) |-> $past(fault_above_hys) && $past(control_at_max))
    else $error("switching started without fault input and control at maximum");
  a_idle_mains_supply: assert property (!switching_enable && !$past(switching_enable) && !aux_open && !$past(aux_open)
    |-> mains_supply_on)
    else $error("mains supply off while not switching");
  a_aux_open_stop: assert property (aux_open |-> ##[0:2] !switching_enable)
    else $error("switching kept after winding sense opened");
  a_aux_no_gate: assert property (aux_open [*3] |=> !gate_start)
    else $error("gate started with winding sense open");
  a_gate_enabled: assert property (gate_start |-> switching_enable)
    else $error("gate started while switching disabled");
  a_valley_start: assert property (gate_start && op_mode == 2'h0 |-> demag_done && valley_seen)
    else $error("valley mode cycle started before demag and valley");
  a_vco_min_peak: assert property (switching_enable && op_mode == 2'h2 && $past(op_mode) == 2'h2 |-> min_peak)
    else $error("oscillator mode without minimum peak");
  // Main scenarios that the bench should reach.
  c_start: cover property ($rose(switching_enable));
  c_burst_gate: cover property (gate_start && op_mode == 2'h3);
  c_aux_stop: cover property ($fell(switching_enable) && aux_open);
endmodule : fbss_sva
bind fbss_top fbss_sva i_fbss_sva (.hclk, .hresetn, .hreadyout, .hresp, .low_rail_below_handover, .fault_above_hys,
  .control_at_max, .aux_open, .demag_done, .valley_seen, .rail_regulator_on, .mains_supply_on, .switching_enable,
  .gate_start, .min_peak, .op_mode);
`default_nettype wire

// >>> fbss_top.sv
// Top of the flyback supervisory sequencer: supply, start-up, modes, protections, registers.
`timescale 1ns/100ps
`default_nettype none
module fbss_top #(
  parameter int unsigned CW = 8,
  parameter int unsigned TICK_LEN = fbss_pkg::TICK_CYCLES
) (
  // Clock, reset and clock enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Supply comparators.
  input wire logic low_rail_start,
  input wire logic low_rail_below_handover,
  input wire logic low_rail_supply_undervoltage_lockout,
  // Mains sampling.
  input wire logic mains_valid,
  input wire logic [CW-1:0] mains_code,
  input wire logic [CW-1:0] mains_brownin_current_level,
  input wire logic [CW-1:0] mains_brownout_level,
  input wire logic [CW-1:0] mains_high_current_level,
  // Feedback and fault input.
  input wire logic fault_above_hys,
  input wire logic fault_low,
  input wire logic control_at_max,
  input wire logic output_in_regulation,
  // Power level decisions from the analog loop.
  input wire logic at_switching_ceiling,
  input wire logic medium_power,
  input wire logic low_power,
  input wire logic osc_due,
  // Winding sense and switching events.
  input wire logic aux_open,
  input wire logic demag_done,
  input wire logic valley_seen,
  input wire logic cycle_end,
  input wire logic ovp_aux,
  input wire logic ovp_rail,
  input wire logic overpower,
  input wire logic otp_internal,
  // Supply and pin controls.
  output logic mains_sense_pin_pull,
  output logic mains_supply_on,
  output logic rail_regulator_on,
  output logic switching_enable,
  output logic soft_start,
  output logic gate_start,
  output logic min_peak,
  output logic sources_enable,
  output logic [1:0] sense_phase,
  output logic opp_limit_sample,
  output logic [1:0] op_mode
);

  fbss_pkg::fbss_state_e st_q, st_d;
  fbss_pkg::fbss_mode_e md_q, md_d;
  logic [17:0] tick_cnt_q;
  logic tick_q;
  logic [6:0] rst_cnt_q;
  logic [7:0] cause_q;
  logic [1:0] ctrl_q;
  logic regulate_q;
  logic reg_done_q;
  logic gate_q;
  logic [1:0] phase_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;

  wire running = (st_q == fbss_pkg::ST_RUN);
  wire sw_en = ctrl_q[fbss_pkg::CTRL_EN_BIT];
  wire m_pull, m_dis, m_bi, m_bo, m_pres;
  wire [CW-1:0] m_code;
  wire p_flt, p_ovp, p_opp, p_ont;

  // One ms timebase; a parameter so simulation can shorten it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 18'h00000;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      tick_q <= tick_cnt_q == 18'(TICK_LEN - 1);
      tick_cnt_q <= (tick_cnt_q == 18'(TICK_LEN - 1)) ? 18'h00000 : tick_cnt_q + 18'h00001;
    end
  end

  fbss_mains #(.CW(CW)) u_mains (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .tick(tick_q),
    .running(running),
    .burst(md_q == fbss_pkg::MD_BURST),
    .sample_valid(mains_valid),
    .sample_code(mains_code),
    .brownin_lvl(mains_brownin_current_level),
    .brownout_lvl(mains_brownout_level),
    .high_lvl(mains_high_current_level),
    .sample_pull(m_pull),
    .discharge(m_dis),
    .above_brownin(m_bi),
    .brownout(m_bo),
    .mains_present(m_pres),
    .last_code(m_code)
  );

  fbss_prot u_prot (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .tick(tick_q),
    .running(running),
    .in_regulation(reg_done_q),
    .gate_rise(gate_start),
    .gate_on(gate_q),
    .fault_low(fault_low),
    .ovp_aux(ovp_aux),
    .ovp_rail(ovp_rail),
    .overpower(overpower),
    .fault_trip(p_flt),
    .ovp_trip(p_ovp),
    .opp_trip(p_opp),
    .ontime_trip(p_ont)
  );

  // Safe-restart class trips; overpower with undervoltage trips at once, without the overpower timer.
  wire restart_trip = p_ont || otp_internal || p_flt || p_ovp || p_opp || (overpower && low_rail_supply_undervoltage_lockout);
  wire start_ok = fault_above_hys && m_bi && control_at_max && !aux_open && sw_en;
  wire [7:0] trip_vec = {low_rail_supply_undervoltage_lockout, p_opp | (overpower & low_rail_supply_undervoltage_lockout), p_ovp, p_flt,
                         otp_internal, p_ont, m_bo, aux_open};
  // A trip keeps its cause bit even against a clear in the same cycle.
  wire [7:0] cause_set = (st_d != st_q && running) ? trip_vec : 8'h00;
  wire [7:0] cause_clr = (wr_q && addr_q == fbss_pkg::CAUSE_OFF) ? hwdata[7:0] : 8'h00;


  // Sequencer next state; open winding sense has highest priority in start wait and run.
  always_comb begin
    st_d = st_q;
    case (st_q)
      fbss_pkg::ST_LOCKOUT: begin
        if (low_rail_start) begin
          st_d = fbss_pkg::ST_WAIT_START;
        end
      end
      fbss_pkg::ST_WAIT_START: begin
        if (aux_open) begin
          st_d = fbss_pkg::ST_AUX_WAIT;
        end else if (start_ok) begin
          st_d = fbss_pkg::ST_RUN;
        end
      end
      fbss_pkg::ST_RUN: begin
        if (aux_open || !sw_en) begin
          st_d = fbss_pkg::ST_AUX_WAIT;
        end else if (restart_trip) begin
          st_d = fbss_pkg::ST_RESTART_WAIT;
        end else if (m_bo) begin
          st_d = fbss_pkg::ST_BROWN_WAIT;
        end else if (low_rail_supply_undervoltage_lockout) begin
          st_d = fbss_pkg::ST_LOCKOUT;
        end
      end
      fbss_pkg::ST_RESTART_WAIT: begin
        if (rst_cnt_q == 7'(fbss_pkg::RESTART_MS) && m_bi) begin
          st_d = fbss_pkg::ST_WAIT_START;
        end
      end
      fbss_pkg::ST_BROWN_WAIT: begin
        if (m_bi) begin
          st_d = fbss_pkg::ST_WAIT_START;
        end
      end
      fbss_pkg::ST_AUX_WAIT: begin
        if (!aux_open && sw_en) begin
          st_d = fbss_pkg::ST_LOCKOUT;
        end
      end
      default: st_d = fbss_pkg::ST_LOCKOUT;
    endcase
  end

  // Mode selection; burst wins over oscillator mode, and both win over the ceiling's valley skipping.
  always_comb begin
    case (1'b1)
      low_power: md_d = fbss_pkg::MD_BURST;
      medium_power: md_d = fbss_pkg::MD_VCO;
      at_switching_ceiling: md_d = fbss_pkg::MD_DCM_SKIP;
      default: md_d = fbss_pkg::MD_VALLEY;
    endcase
  end

  // Valley-based modes wait for demag and valley; oscillator modes also pace by the oscillator.
  wire valley_ok = demag_done && valley_seen;
  wire start_cycle = running && !gate_q && ((md_q == fbss_pkg::MD_VALLEY) ? valley_ok :
                     (md_q == fbss_pkg::MD_DCM_SKIP) ? valley_ok && !at_switching_ceiling :
                     valley_ok && osc_due);

  // State, mode, restart timer and cycle phase registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= fbss_pkg::ST_LOCKOUT;
      md_q <= fbss_pkg::MD_VALLEY;
      rst_cnt_q <= 7'h00;
      gate_q <= 1'b0;
      phase_q <= 2'h0;
      regulate_q <= 1'b0;
      reg_done_q <= 1'b0;
      cause_q <= 8'h00;
    end else if (clk_en) begin
      st_q <= st_d;
      md_q <= md_d;
      if (st_q != fbss_pkg::ST_RESTART_WAIT) begin
        rst_cnt_q <= 7'h00;
      end else if (tick_q && rst_cnt_q < 7'(fbss_pkg::RESTART_MS)) begin
        rst_cnt_q <= rst_cnt_q + 7'h01;
      end
      gate_q <= !running || restart_trip || aux_open ? 1'b0 : (start_cycle ? 1'b1 : (cycle_end ? 1'b0 : gate_q));
      // Phase: 0 on-time (input), 1 demag/output, 2 valley wait.
      phase_q <= gate_q ? 2'h0 : (demag_done ? 2'h2 : 2'h1);
      // Regulation from mains holds until the feedback reports the output in regulation.
      if (st_q == fbss_pkg::ST_WAIT_START || st_q == fbss_pkg::ST_RESTART_WAIT) begin
        regulate_q <= 1'b1;
        reg_done_q <= 1'b0;
      end else if (running && output_in_regulation) begin
        regulate_q <= 1'b0;
        reg_done_q <= 1'b1;
      end
      // Cause bits are sticky and write-one-to-clear.
      cause_q <= (cause_q & ~cause_clr) | cause_set;
    end
  end

  // Supply handover and per-protection regulation choice.
  wire stopped_reg = (st_q == fbss_pkg::ST_RESTART_WAIT) || (st_q == fbss_pkg::ST_BROWN_WAIT);
  assign mains_supply_on = (st_q == fbss_pkg::ST_LOCKOUT) || stopped_reg || (st_q == fbss_pkg::ST_WAIT_START)
                           || (running && regulate_q);
  assign rail_regulator_on = low_rail_below_handover;
  assign mains_sense_pin_pull = m_pull;
  assign switching_enable = running;
  assign soft_start = running && !reg_done_q;
  assign sources_enable = (st_q == fbss_pkg::ST_WAIT_START) || running;
  assign gate_start = start_cycle;
  assign min_peak = md_q == fbss_pkg::MD_VCO;
  assign sense_phase = phase_q;
  assign opp_limit_sample = gate_q;
  assign op_mode = md_q;

  // AHB-Lite: capture address phase, act in data phase, zero wait states.
  wire take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      ctrl_q <= fbss_pkg::CTRL_RESET;
      rdata_q <= 32'h00000000;
    end else if (clk_en) begin
      wr_q <= take && hwrite;
      addr_q <= haddr;
      if (wr_q && addr_q == fbss_pkg::CTRL_OFF) begin
        ctrl_q <= hwdata[1:0];
      end
      if (take && !hwrite) begin
        case (haddr)
          fbss_pkg::CTRL_OFF: rdata_q <= {30'h00000000, ctrl_q};
          fbss_pkg::STAT_OFF: rdata_q <= {21'h000000, m_pres, m_dis, m_bi, m_bo, md_q, 1'b0, st_q, regulate_q};
          fbss_pkg::MAINS_OFF: rdata_q <= 32'(m_code);
          fbss_pkg::CAUSE_OFF: rdata_q <= {24'h000000, cause_q};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : fbss_top
`default_nettype wire

// >>> fbss_top_tb.sv
// Self-checking testbench for the flyback supervisory sequencer.
`timescale 1ns/100ps
`default_nettype none
module fbss_top_tb;
  logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0, low_rail_start = 1'b0;
  logic low_rail_below_handover = 1'b0, fault_above_hys = 1'b0, control_at_max = 1'b0, output_in_regulation = 1'b0;
  logic at_switching_ceiling = 1'b0, medium_power = 1'b0, low_power = 1'b0, aux_open = 1'b0, osc_due = 1'b1;
  logic [2:0] hsize = 3'h2;
  logic [5:0] trip = 6'h0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00, amp = 8'hc0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, mains_valid, demag_done, valley_seen, cycle_end, mains_sense_pin_pull, mains_supply_on;
  logic rail_regulator_on, switching_enable, gate_start, min_peak, soft_start, sources_enable, opp_limit_sample;
  logic [7:0] mains_code;
  logic [1:0] op_mode, sense_phase;
  int n_mismatch = 0, checks_done = 0, n, run;
  int cb [6] = '{fbss_pkg::CS_OTP, fbss_pkg::CS_OVP, fbss_pkg::CS_OVP, fbss_pkg::CS_FLT, fbss_pkg::CS_OPP, fbss_pkg::CS_UV};

  // Short timebase keeps the millisecond waits to tens of cycles.
  fbss_top #(.CW(8), .TICK_LEN(10)) i_fbss_top (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .low_rail_start, .low_rail_below_handover,
    .low_rail_supply_undervoltage_lockout(trip[5]), .mains_valid, .mains_code, .mains_brownin_current_level(8'h60),
    .mains_brownout_level(8'h40), .mains_high_current_level(8'ha0), .fault_above_hys, .fault_low(trip[3]),
    .control_at_max, .output_in_regulation, .at_switching_ceiling, .medium_power, .low_power, .osc_due,
    .aux_open, .demag_done, .valley_seen, .cycle_end, .ovp_aux(trip[1]), .ovp_rail(trip[2]), .overpower(trip[4]),
    .otp_internal(trip[0]), .mains_sense_pin_pull, .mains_supply_on, .rail_regulator_on, .switching_enable,
    .soft_start, .gate_start, .min_peak, .sources_enable, .sense_phase, .opp_limit_sample, .op_mode);
  fbss_stage_model i_fbss_stage_model (.hclk, .hresetn, .pull(mains_sense_pin_pull), .gate_start, .amp,
    .mains_valid, .mains_code, .demag_done, .valley_seen, .cycle_end);

  // The 250 MHz core clock.
  always #2 hclk = ~hclk;

  // Verdict and stop; also reached from any wait that runs out.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic tmo(input int lim);
    if (n >= lim) begin
      n_mismatch++;
      $display("[FAIL] wait expected done seen timeout");
      report_and_stop();
    end
  endtask : tmo

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  // Waits for the next edge that samples ready high; the master never assumes a latency.
  task automatic rdy();
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    tmo(50);
  endtask : rdy

  // One single word transfer; read data lands in q at the end of the data phase.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask : ahb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
    ahb(1'b0, a, 32'h0);
    chk(w, e, q & m);
  endtask : rd

  function automatic logic pick(input int s);
    return s == 0 ? switching_enable : s == 1 ? mains_supply_on : s == 2 ? mains_sense_pin_pull : opp_limit_sample;
  endfunction : pick

  task automatic wait_for(input int s, input logic want, input int lim);
    n = 0;
    while (pick(s) !== want && n < lim) begin
      @(posedge hclk);
      n++;
    end
    tmo(lim);
  endtask : wait_for

  // Main sequence: registers, start-up, modes, protections, open winding, brownout and discharge.
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(fbss_pkg::CTRL_OFF, 32'h3, 32'h1, "ctrl reset");
    rd(fbss_pkg::CAUSE_OFF, 32'hff, 32'h0, "cause reset");
    ahb(1'b1, 8'h40, 32'hffffffff);
    rd(8'h40, 32'hffffffff, 32'h0, "unmapped read");
    low_rail_below_handover <= 1'b1;
    @(posedge hclk);
    chk("regulator on", 32'h1, {31'h0, rail_regulator_on});
    low_rail_below_handover <= 1'b0;
    $display("test registers done");
    low_rail_start <= 1'b1;
    fault_above_hys <= 1'b1;
    repeat (300) @(posedge hclk);
    chk("start without control max", 32'h0, {31'h0, switching_enable});
    control_at_max <= 1'b1;
    clk_en <= 1'b0;
    repeat (100) @(posedge hclk);
    chk("frozen by clock enable", 32'h0, {31'h0, switching_enable});
    clk_en <= 1'b1;
    wait_for(0, 1'b1, 2000);
    chk("mains supply in start-up", 32'h1, {31'h0, mains_supply_on});
    chk("soft start", 32'h1, {31'h0, soft_start});
    chk("sources on", 32'h1, {31'h0, sources_enable});
    output_in_regulation <= 1'b1;
    wait_for(1, 1'b0, 500);
    chk("soft start over", 32'h0, {31'h0, soft_start});
    $display("test start-up done");
    for (int i = 0; i < 4; i++) begin
      {at_switching_ceiling, medium_power, low_power} <= 3'h4 >> i;
      n = 0;
      while (op_mode !== 2'(i + 1) && n < 500) begin
        @(posedge hclk);
        n++;
      end
      tmo(500);
      chk("op mode", 32'(i + 1) & 32'h3, {30'h0, op_mode});
    end
    wait_for(3, 1'b0, 100);
    wait_for(3, 1'b1, 100);
    repeat (2) @(posedge hclk);
    chk("on-time phase", 32'h0, {30'h0, sense_phase});
    $display("test modes done");
    for (int k = 0; k < 6; k++) begin
      trip <= 6'h1 << k;
      wait_for(0, 1'b0, 4000);
      trip <= 6'h0;
      rd(fbss_pkg::CAUSE_OFF, 32'h1 << cb[k], 32'h1 << cb[k], "cause bit");
      ahb(1'b1, fbss_pkg::CAUSE_OFF, 32'hff);
      rd(fbss_pkg::CAUSE_OFF, 32'hff, 32'h0, "cause cleared");
      wait_for(0, 1'b1, 3000);
    end
    $display("test protections done");
    aux_open <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("aux open stop", 32'h0, {31'h0, switching_enable});
    aux_open <= 1'b0;
    wait_for(0, 1'b1, 3000);
    $display("test open winding done");
    amp <= 8'h10;
    wait_for(0, 1'b0, 1000);
    rd(fbss_pkg::CAUSE_OFF, 32'h1 << fbss_pkg::CS_BO, 32'h1 << fbss_pkg::CS_BO, "brownout cause");
    n = 0;
    run = 0;
    while (run < 20 && n < 3000) begin
      @(posedge hclk);
      n++;
      run = mains_sense_pin_pull ? run + 1 : 0;
    end
    tmo(3000);
    chk("discharge held", 32'h1, {31'h0, mains_sense_pin_pull});
    $display("test brownout done");
    report_and_stop();
  end
endmodule : fbss_top_tb
`default_nettype wire
